// ==== shared/fec_defs.svh ====
// Purpose: named code-groups, nibbles and counts of the 4B/5B codec
// Assumes: included by bare name from the design files
// Notes: code-groups are listed MSB first, MSB goes on the line first
`ifndef FEC_DEFS_SVH
`define FEC_DEFS_SVH
`define FEC_D0          5'h1E
`define FEC_D1          5'h09
`define FEC_D2          5'h14
`define FEC_D3          5'h15
`define FEC_D4          5'h0A
`define FEC_D5          5'h0B
`define FEC_D6          5'h0E
`define FEC_D7          5'h0F
`define FEC_D8          5'h12
`define FEC_D9          5'h13
`define FEC_DA          5'h16
`define FEC_DB          5'h17
`define FEC_DC          5'h1A
`define FEC_DD          5'h1B
`define FEC_DE          5'h1C
`define FEC_DF          5'h1D
`define FEC_SYM_H       5'h04
`define FEC_SYM_I       5'h1F
`define FEC_SYM_J       5'h18
`define FEC_SYM_K       5'h11
`define FEC_SYM_T       5'h0D
`define FEC_SYM_R       5'h07
`define FEC_SYM_P       5'h00
`define FEC_NIB_PRE     4'h5
`define FEC_NIB_IDLE    4'h0
`define FEC_NIB_LPI     4'h1
`define FEC_LFSR_SEED   11'h7FF
`define FEC_TAP_HI      10
`define FEC_TAP_LO      8
`define FEC_LOCK_LAST   7'h57
`define FEC_ZERO_LAST   2'h2
`define FEC_SYM_LAST    3'h4
`define FEC_CLK_MHZ     100
`define FEC_LINE_MBPS   125
`endif

// ==== shared/fec_pkg.sv ====
// Purpose: types shared by the codec and its testbench
// Assumes: nothing
// Notes: en doubles as rx data-valid on the receive side
package fec_pkg;
    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] d;
    } fec_mii_s;
    typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fec_tx_e;
    typedef enum logic [2:0] {RX_HUNT, RX_IDLE, RX_K, RX_DATA, RX_END} fec_rx_e;
endpackage

// ==== src/fec_fifo.sv ====
// Purpose: small flop fifo between mac nibbles and the encoder
// Assumes: one clock, async active-low reset
// Notes: in_ready is registered so it can leave the block directly
`timescale 1ns/1ns
`default_nettype none
module fec_fifo #(
    parameter int W = 6,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;
    logic [AW:0]   cnt_d;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
        return (p == AW'(D-1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q     <= '0;
            rd_q     <= '0;
            cnt_q    <= '0;
            in_ready <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            in_ready <= (cnt_d != (AW+1)'(D));
            if (push) begin
                wr_q <= wrap(wr_q);
            end
            if (pop) begin
                rd_q <= wrap(rd_q);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ==== src/fec_codec.sv ====
// Purpose: 100 Mb/s 4B/5B coding, scrambling and NRZI of a twisted-pair phy
// Assumes: mac logic runs on core_clk; rx_line and scr_bypass are pins
// Notes: one line bit per bit_stb, five bits per symbol slot
//
// How it works
// - each mac nibble becomes one 5-bit code-group
// - fixed sixteen-entry data table, used both ways
// - halt code-group 00100 decodes as a receive error
// - idle is 11111 and decodes to nibble 0000
// - invalid groups and control groups other than T inside data raise rx error
// - low-power idle is 00000 with error set and enable low
// - first two preamble nibbles are replaced by J then K
// - enable falling appends T then R
// - idle fills the line until enable rises again
// - symbols leave as a serial bit stream, one bit per enable
// - 11-bit lfsr output is xored onto every serial bit
// - a pin removes the scrambler from the transmit path
// - receive side rebuilds the key and xors it off
// - 88 consecutive descrambled ones lock the descrambler
// - while locked, idle before J is checked bit by bit
// - three zeros that are not J drop lock
// - a symbol after J other than K drops lock
// - the scrambled stream is always NRZI coded
`timescale 1ns/1ns
`default_nettype none
`include "fec_defs.svh"
module fec_codec #(
    parameter int BIT_DIV = 1,
    parameter int FIFO_D  = 8
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             tx_valid,
    output var  logic             tx_ready,
    input  wire fec_pkg::fec_mii_s tx_mii,
    input  wire logic             scr_bypass,
    output logic                  tx_line_q,
    input  wire logic             rx_line,
    output fec_pkg::fec_mii_s     rx_mii_q,
    output logic                  rx_stb_q,
    output logic                  rx_lock_q
);
    // core_clk cannot reach the line rate; BIT_DIV=1 runs one bit per clock
    localparam int LINE_CYC = (`FEC_CLK_MHZ + `FEC_LINE_MBPS - 1) / `FEC_LINE_MBPS;
    localparam int DIV_N    = (BIT_DIV > LINE_CYC) ? BIT_DIV : LINE_CYC;

    function automatic logic [4:0] enc4(input logic [3:0] n);
        case (n)
            4'h0: enc4 = `FEC_D0;
            4'h1: enc4 = `FEC_D1;
            4'h2: enc4 = `FEC_D2;
            4'h3: enc4 = `FEC_D3;
            4'h4: enc4 = `FEC_D4;
            4'h5: enc4 = `FEC_D5;
            4'h6: enc4 = `FEC_D6;
            4'h7: enc4 = `FEC_D7;
            4'h8: enc4 = `FEC_D8;
            4'h9: enc4 = `FEC_D9;
            4'hA: enc4 = `FEC_DA;
            4'hB: enc4 = `FEC_DB;
            4'hC: enc4 = `FEC_DC;
            4'hD: enc4 = `FEC_DD;
            4'hE: enc4 = `FEC_DE;
            default: enc4 = `FEC_DF;
        endcase
    endfunction

    // bit 4 flags a data group; all else, invalid groups included, is not data
    function automatic logic [4:0] dec5(input logic [4:0] s);
        case (s)
            `FEC_D0: dec5 = 5'h10;
            `FEC_D1: dec5 = 5'h11;
            `FEC_D2: dec5 = 5'h12;
            `FEC_D3: dec5 = 5'h13;
            `FEC_D4: dec5 = 5'h14;
            `FEC_D5: dec5 = 5'h15;
            `FEC_D6: dec5 = 5'h16;
            `FEC_D7: dec5 = 5'h17;
            `FEC_D8: dec5 = 5'h18;
            `FEC_D9: dec5 = 5'h19;
            `FEC_DA: dec5 = 5'h1A;
            `FEC_DB: dec5 = 5'h1B;
            `FEC_DC: dec5 = 5'h1C;
            `FEC_DD: dec5 = 5'h1D;
            `FEC_DE: dec5 = 5'h1E;
            `FEC_DF: dec5 = 5'h1F;
            default: dec5 = 5'h00;
        endcase
    endfunction

    function automatic logic key(input logic [10:0] l);
        return l[`FEC_TAP_HI] ^ l[`FEC_TAP_LO];
    endfunction

    // bit enable divider
    logic [7:0] div_q;
    logic       bit_stb;
    assign bit_stb = (div_q == 8'(DIV_N - 1));

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= '0;
        end else begin
            div_q <= bit_stb ? '0 : div_q + 8'h01;
        end
    end

    // pin synchronisers
    logic byp_m_q;
    logic byp_q;
    logic rx_m_q;
    logic rx_s_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            byp_m_q <= 1'b0;
            byp_q   <= 1'b0;
            rx_m_q  <= 1'b0;
            rx_s_q  <= 1'b0;
        end else begin
            byp_m_q <= scr_bypass;
            byp_q   <= byp_m_q;
            rx_m_q  <= rx_line;
            rx_s_q  <= rx_m_q;
        end
    end

    // transmit nibble fifo, drained once per symbol slot except the slot that sends R
    fec_pkg::fec_mii_s ent_raw;
    fec_pkg::fec_mii_s ent;
    fec_pkg::fec_tx_e  tx_st_q;
    fec_pkg::fec_tx_e  tx_st_d;
    logic              ent_vld;
    logic              pop;
    logic [2:0]        tbc_q;
    logic              sym_stb;
    logic [4:0]        sym_q;
    logic [4:0]        sym_d;

    assign sym_stb = bit_stb && (tbc_q == `FEC_SYM_LAST);
    assign pop     = sym_stb && (tx_st_q != fec_pkg::TX_R);
    assign ent     = ent_vld ? ent_raw : '0;

    fec_fifo #(
        .W ($bits(fec_pkg::fec_mii_s)),
        .D (FIFO_D)
    ) u_txq (
        .clk       (core_clk),
        .reset_n   (reset_n),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_mii),
        .out_valid (ent_vld),
        .out_ready (pop),
        .out_data  (ent_raw)
    );

    // an empty fifo mid-frame reads as enable low and ends the frame
    always_comb begin
        tx_st_d = tx_st_q;
        sym_d   = `FEC_SYM_I;
        case (tx_st_q)
            fec_pkg::TX_IDLE: begin
                if (ent.en) begin
                    sym_d   = `FEC_SYM_J;
                    tx_st_d = fec_pkg::TX_K;
                end else if (ent.er && ent.d == `FEC_NIB_LPI) begin
                    sym_d = `FEC_SYM_P;
                end
            end
            fec_pkg::TX_K: begin
                sym_d   = `FEC_SYM_K;
                tx_st_d = fec_pkg::TX_DATA;
            end
            fec_pkg::TX_DATA: begin
                if (!ent.en) begin
                    sym_d   = `FEC_SYM_T;
                    tx_st_d = fec_pkg::TX_R;
                end else if (ent.er) begin
                    sym_d = `FEC_SYM_H;
                end else begin
                    sym_d = enc4(ent.d);
                end
            end
            fec_pkg::TX_R: begin
                sym_d   = `FEC_SYM_R;
                tx_st_d = fec_pkg::TX_IDLE;
            end
            default: begin
                tx_st_d = fec_pkg::TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_st_q <= fec_pkg::TX_IDLE;
            tbc_q   <= '0;
            sym_q   <= `FEC_SYM_I;
        end else if (bit_stb) begin
            if (sym_stb) begin
                tbc_q   <= '0;
                sym_q   <= sym_d;
                tx_st_q <= tx_st_d;
            end else begin
                tbc_q <= tbc_q + 3'h1;
                sym_q <= {sym_q[3:0], 1'b0};
            end
        end
    end

    // scrambler and nrzi line driver
    logic [10:0] tl_q;
    logic        tx_key;
    logic        tx_bit;
    assign tx_key = key(tl_q);
    assign tx_bit = sym_q[4] ^ (tx_key & ~byp_q);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tl_q      <= `FEC_LFSR_SEED;
            tx_line_q <= 1'b0;
        end else if (bit_stb) begin
            tl_q      <= {tl_q[9:0], tx_key};
            tx_line_q <= tx_line_q ^ tx_bit;
        end
    end

    // receive: nrzi decode and descrambler locked on idle
    logic        rx_prev_q;
    logic        sd;
    logic [10:0] rl_q;
    logic        rx_key;
    logic        ud;
    logic [4:0]  hist_q;
    logic [4:0]  cur5;
    logic [4:0]  dec;
    logic [6:0]  ones_q;
    logic [1:0]  zrun_q;
    logic [2:0]  rbc_q;
    fec_pkg::fec_rx_e rx_st_q;

    assign sd     = rx_s_q ^ rx_prev_q;
    assign rx_key = key(rl_q);
    assign ud     = sd ^ rx_key;
    assign cur5   = {hist_q[3:0], ud};
    assign dec    = dec5(cur5);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_prev_q <= 1'b0;
            rl_q      <= `FEC_LFSR_SEED;
            hist_q    <= '0;
        end else if (bit_stb) begin
            rx_prev_q <= rx_s_q;
            hist_q    <= cur5;
            // unlocked: idle is all ones, so the key is the inverted line bit
            if (rx_st_q == fec_pkg::RX_HUNT) begin
                rl_q <= {rl_q[9:0], ~sd};
            end else begin
                rl_q <= {rl_q[9:0], rx_key};
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_st_q   <= fec_pkg::RX_HUNT;
            ones_q    <= '0;
            zrun_q    <= '0;
            rbc_q     <= '0;
            rx_mii_q  <= '0;
            rx_stb_q  <= 1'b0;
            rx_lock_q <= 1'b0;
        end else begin
            rx_stb_q <= 1'b0;
            if (bit_stb) begin
                rbc_q <= (rbc_q == `FEC_SYM_LAST) ? '0 : rbc_q + 3'h1;
                case (rx_st_q)
                    fec_pkg::RX_HUNT: begin
                        if (!ud) begin
                            ones_q <= '0;
                        end else if (ones_q == `FEC_LOCK_LAST) begin
                            ones_q    <= '0;
                            zrun_q    <= '0;
                            rx_lock_q <= 1'b1;
                            rx_st_q   <= fec_pkg::RX_IDLE;
                        end else begin
                            ones_q <= ones_q + 7'h01;
                        end
                    end
                    fec_pkg::RX_IDLE: begin
                        if (ud) begin
                            zrun_q <= '0;
                        end else if (zrun_q != `FEC_ZERO_LAST) begin
                            zrun_q <= zrun_q + 2'h1;
                        end else if (cur5 == `FEC_SYM_J) begin
                            rbc_q   <= '0;
                            rx_st_q <= fec_pkg::RX_K;
                        end else begin
                            rx_lock_q <= 1'b0;
                            rx_st_q   <= fec_pkg::RX_HUNT;
                        end
                    end
                    fec_pkg::RX_K: begin
                        if (rbc_q == `FEC_SYM_LAST) begin
                            if (cur5 == `FEC_SYM_K) begin
                                rx_mii_q <= '{en: 1'b1, er: 1'b0, d: `FEC_NIB_PRE};
                                rx_stb_q <= 1'b1;
                                rx_st_q  <= fec_pkg::RX_DATA;
                            end else begin
                                rx_lock_q <= 1'b0;
                                rx_st_q   <= fec_pkg::RX_HUNT;
                            end
                        end
                    end
                    fec_pkg::RX_DATA: begin
                        if (rbc_q == `FEC_SYM_LAST) begin
                            rx_stb_q <= 1'b1;
                            if (cur5 == `FEC_SYM_T) begin
                                rx_mii_q <= '0;
                                rx_st_q  <= fec_pkg::RX_END;
                            end else if (dec[4]) begin
                                rx_mii_q <= '{en: 1'b1, er: 1'b0, d: dec[3:0]};
                            end else begin
                                // halt, invalid and stray control groups
                                rx_mii_q <= '{en: 1'b1, er: 1'b1, d: `FEC_NIB_IDLE};
                                if (cur5 == `FEC_SYM_I) begin
                                    zrun_q  <= '0;
                                    rx_st_q <= fec_pkg::RX_IDLE;
                                end
                            end
                        end
                    end
                    fec_pkg::RX_END: begin
                        // a missing R is not reported; idle check takes over
                        if (rbc_q == `FEC_SYM_LAST) begin
                            zrun_q  <= '0;
                            rx_st_q <= fec_pkg::RX_IDLE;
                        end
                    end
                    default: begin
                        rx_lock_q <= 1'b0;
                        rx_st_q   <= fec_pkg::RX_HUNT;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/fec_codec_chk.sv ====
// Purpose: port-level assertions for fec_codec
// Assumes: BIT_DIV 1 for the symbol-spacing checks
// Notes: idle check only holds with the scrambler bypassed
`timescale 1ns/1ns
`default_nettype none
module fec_codec_chk #(
    parameter int BIT_DIV = 1,
    parameter int FIFO_D  = 8
) (
    input wire logic              core_clk,
    input wire logic              reset_n,
    input wire logic              tx_valid,
    input wire logic              tx_ready,
    input wire fec_pkg::fec_mii_s tx_mii,
    input wire logic              scr_bypass,
    input wire logic              tx_line_q,
    input wire logic              rx_line,
    input wire fec_pkg::fec_mii_s rx_mii_q,
    input wire logic              rx_stb_q,
    input wire logic              rx_lock_q
);
    logic [6:0] quiet_q;
    logic [6:0] unlocked_q;
    logic       byp_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            byp_q <= 1'b0;
        end else begin
            byp_q <= scr_bypass;
        end
    end
    // 64 quiet cycles cover a full fifo plus the end pair
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            quiet_q <= 7'h00;
        end else if ((tx_valid && tx_ready) || (scr_bypass != byp_q)) begin
            quiet_q <= 7'h00;
        end else if (quiet_q != 7'h7F) begin
            quiet_q <= quiet_q + 7'h01;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            unlocked_q <= 7'h00;
        end else if (rx_lock_q) begin
            unlocked_q <= 7'h00;
        end else if (unlocked_q != 7'h7F) begin
            unlocked_q <= unlocked_q + 7'h01;
        end
    end
    sequence s_gap;
        !rx_stb_q [*4];
    endsequence
    property p_stb_gap;
        (BIT_DIV == 1) && rx_stb_q |=> s_gap;
    endproperty
    a_stb_gap: assert property (p_stb_gap)
        else $error("rx strobes closer than one symbol");
    property p_stb_locked;
        rx_stb_q |-> rx_lock_q;
    endproperty
    a_stb_locked: assert property (p_stb_locked)
        else $error("rx strobe while unlocked");
    property p_err_form;
        rx_stb_q && rx_mii_q.er |-> rx_mii_q.en && rx_mii_q.d == 4'h0;
    endproperty
    a_err_form: assert property (p_err_form)
        else $error("rx error nibble malformed");
    property p_end_form;
        rx_stb_q && !rx_mii_q.en |-> !rx_mii_q.er && rx_mii_q.d == 4'h0;
    endproperty
    a_end_form: assert property (p_end_form)
        else $error("end of frame nibble malformed");
    property p_mii_hold;
        !rx_stb_q |-> $stable(rx_mii_q);
    endproperty
    a_mii_hold: assert property (p_mii_hold)
        else $error("rx nibble changed without strobe");
    property p_ready_fall;
        $fell(tx_ready) |-> $past(tx_valid && tx_ready);
    endproperty
    a_ready_fall: assert property (p_ready_fall)
        else $error("tx ready fell without a push");
    property p_idle_toggle;
        (BIT_DIV == 1) && scr_bypass && quiet_q[6] |-> tx_line_q != $past(tx_line_q);
    endproperty
    a_idle_toggle: assert property (p_idle_toggle)
        else $error("bypassed idle line not toggling");
    property p_lock_delay;
        $rose(rx_lock_q) |-> unlocked_q >= 7'h58;
    endproperty
    a_lock_delay: assert property (p_lock_delay)
        else $error("lock before 88 bits");
endmodule
bind fec_codec fec_codec_chk #(.BIT_DIV(BIT_DIV), .FIFO_D(FIFO_D)) i_fec_codec_chk (
    .core_clk(core_clk), .reset_n(reset_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_mii(tx_mii), .scr_bypass(scr_bypass), .tx_line_q(tx_line_q), .rx_line(rx_line),
    .rx_mii_q(rx_mii_q), .rx_stb_q(rx_stb_q), .rx_lock_q(rx_lock_q));
`default_nettype wire

// ==== testbench/fec_mac_model.sv ====
// Purpose: mac side model: pushes nibbles, collects rx nibbles
// Assumes: outputs change 1 ns after the rising edge
// Notes: released data lines show the inverse of the last nibble
`timescale 1ns/1ns
`default_nettype none
module fec_mac_model (
    input  wire logic              core_clk,
    output var  logic              tx_valid,
    input  wire logic              tx_ready,
    output var  fec_pkg::fec_mii_s tx_mii,
    input  wire fec_pkg::fec_mii_s rx_mii,
    input  wire logic              rx_stb
);
    fec_pkg::fec_mii_s rx_q[$];
    int                refused = 0;
    int                ok = 1;
    initial begin
        tx_valid = 1'b0;
        tx_mii   = '0;
    end
    task automatic send(input logic [5:0] e);
        int n;
        n = 0;
        tx_valid = 1'b1;
        tx_mii   = e;
        while (tx_ready !== 1'b1 && n < 200) begin
            refused++;
            n++;
            @(posedge core_clk);
            #1;
        end
        if (n == 200) ok = 0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic release_bus();
        tx_valid = 1'b0;
        tx_mii   = ~tx_mii;
    endtask
    // strobe is a one-cycle pulse, so sample away from the edge
    always @(negedge core_clk) begin
        if (rx_stb === 1'b1) rx_q.push_back(rx_mii);
    end
endmodule
`default_nettype wire

// ==== testbench/fec_codec_bench.sv ====
// Purpose: self-checking bench for fec_codec, line looped to receiver
// Assumes: BIT_DIV 1, one line bit per core_clk
// Notes: tx groups are read back with the scrambler bypassed
`timescale 1ns/1ns
`default_nettype none
`include "fec_defs.svh"
module fec_codec_bench;
    logic              core_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              scr_bypass = 1'b0;
    logic              tx_valid;
    logic              tx_ready;
    fec_pkg::fec_mii_s tx_mii;
    logic              tx_line_q;
    fec_pkg::fec_mii_s rx_mii_q;
    logic              rx_stb_q;
    logic              rx_lock_q;
    logic              prev_line = 1'b0;
    logic              cap = 1'b0;
    logic              bits[$];
    int                miscompares = 0;
    int                tests_run = 0;
    logic [4:0]        dcode[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                     5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    fec_codec #(.BIT_DIV(1), .FIFO_D(8)) i_fec_codec (
        .core_clk(core_clk), .reset_n(reset_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_mii(tx_mii), .scr_bypass(scr_bypass), .tx_line_q(tx_line_q),
        .rx_line(tx_line_q), .rx_mii_q(rx_mii_q), .rx_stb_q(rx_stb_q), .rx_lock_q(rx_lock_q));
    fec_mac_model i_fec_mac_model (
        .core_clk(core_clk), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_mii(tx_mii),
        .rx_mii(rx_mii_q), .rx_stb(rx_stb_q));
    always #5 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        if (cap) bits.push_back(tx_line_q ^ prev_line);
        prev_line = tx_line_q;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic wait_lock(input logic want, input int lim);
        int n;
        n = 0;
        while (rx_lock_q !== want && n < lim) begin
            n++;
            @(posedge core_clk);
            #1;
        end
        check(n < lim, "lock state not reached");
        if (n == lim) summarize();
    endtask
    task automatic frame(input logic [5:0] ent[$]);
        foreach (ent[i]) i_fec_mac_model.send(ent[i]);
        i_fec_mac_model.release_bus();
        check(i_fec_mac_model.ok == 1, "mac push stalled");
        // a stalled push is a timeout: stop here rather than judge garbage
        if (i_fec_mac_model.ok != 1) summarize();
    endtask
    // lead: ones that open the first group before its first zero
    task automatic groups(input int lead, input logic [4:0] exp[$]);
        int         z;
        logic [4:0] g;
        z = 0;
        while (z < bits.size() && bits[z] === 1'b1) z++;
        z = z - lead;
        foreach (exp[i]) begin
            g = 5'h00;
            for (int b = 0; b < 5; b++) g = {g[3:0], bits[z + 5 * i + b]};
            check(g === exp[i], "tx code-group");
        end
    endtask
    task automatic t_rx_loop();
        int ones;
        logic [5:0] ent[$];
        logic [5:0] exp[$];
        ones = 0;
        wait_lock(1'b1, 400);
        bits = {};
        cap = 1'b1;
        repeat (30) @(posedge core_clk);
        #1 cap = 1'b0;
        foreach (bits[i]) ones += int'(bits[i]);
        check(ones < 30, "idle left unscrambled");
        i_fec_mac_model.rx_q = {};
        // every data nibble once, so each decode entry is exercised
        ent = {6'h25, 6'h25};
        exp = {6'h25};
        for (int i = 0; i < 16; i++) begin
            ent.push_back({2'b10, 4'(i)});
            exp.push_back({2'b10, 4'(i)});
        end
        ent = {ent, 6'h33, 6'h00};
        exp = {exp, 6'h30, 6'h00};
        frame(ent);
        repeat (150) @(posedge core_clk);
        #1 check(i_fec_mac_model.rx_q.size() == exp.size(), "rx nibble count");
        foreach (exp[i]) check(i_fec_mac_model.rx_q[i] === exp[i], "rx nibble");
    endtask
    task automatic t_unlock();
        scr_bypass = 1'b1;
        wait_lock(1'b0, 300);
        repeat (10) @(posedge core_clk);
        #1;
    endtask
    task automatic t_tx_frame();
        logic [5:0] ent[$];
        logic [4:0] exp[$];
        ent = '{6'h25, 6'h25};
        exp = '{`FEC_SYM_J, `FEC_SYM_K};
        for (int i = 0; i < 16; i++) begin
            ent.push_back({2'b10, 4'(i)});
            exp.push_back(dcode[i]);
        end
        ent.push_back(6'h33);
        ent.push_back(6'h00);
        exp = {exp, `FEC_SYM_H, `FEC_SYM_T, `FEC_SYM_R, `FEC_SYM_I};
        bits = {};
        cap = 1'b1;
        frame(ent);
        repeat (60) @(posedge core_clk);
        #1 cap = 1'b0;
        groups(2, exp);
        check(i_fec_mac_model.refused > 0, "fifo never filled");
        check(tx_ready === 1'b1, "fifo not drained");
    endtask
    task automatic t_tx_lpi();
        bits = {};
        cap = 1'b1;
        frame('{6'h11});
        repeat (30) @(posedge core_clk);
        #1 cap = 1'b0;
        groups(0, '{`FEC_SYM_P, `FEC_SYM_I});
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        #1 reset_n = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 check(tx_ready === 1'b1, "ready after reset");
        t_rx_loop();
        t_unlock();
        t_tx_frame();
        t_tx_lpi();
        summarize();
    end
endmodule
`default_nettype wire
